// file: privileged_handler_dispatch.sv
// Purpose: steer the core into and out of privileged handler mode
// Assumes: pipeline reports drain completion; one event at a time
// Notes:   target pc goes out registered with a one-cycle valid
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module privileged_handler_dispatch #(
    parameter int SCRATCH_N = handler_dispatch_pkg::SCRATCH_N
) (
    // clock and reset
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_rst_n,
    // trap sources from the pipeline
    input  wire handler_dispatch_pkg::trap_req_t i_trap,
    input  wire logic                        i_replay,
    input  wire logic                        i_dsign_err,
    input  wire logic                        i_icache_miss,
    input  wire logic                        i_float_op,
    input  wire logic                        i_float_bad_type,
    input  wire logic                        i_trap_precise,
    input  wire logic [63:0]                 i_trap_pc,
    input  wire logic [63:0]                 i_later_pc,
    // handler call and return
    input  wire logic                        i_call,
    input  wire logic [7:0]                  i_call_func,
    input  wire logic [63:0]                 i_call_next_pc,
    input  wire logic                        i_return,
    input  wire logic                        i_drained,
    // internal register moves
    input  wire logic                        i_ipr_wr,
    input  wire logic                        i_ipr_rd,
    input  wire logic [5:0]                  i_ipr_sel,
    input  wire logic [63:0]                 i_ipr_wdata,
    input  wire logic                        i_shadow_enable,
    input  wire logic                        i_float_enable,
    input  wire logic [1:0]                  i_current_mode_field,
    // general register access from execution
    input  wire handler_dispatch_pkg::gpr_acc_t i_gpr,
    // outputs to fetch and issue
    output logic                             o_redirect,
    output logic [63:0]                      o_target_pc,
    output logic [63:0]                      o_fetch_pc,
    output logic                             o_priv_mode,
    output logic                             o_istream_map_en,
    output logic                             o_dstream_map_en,
    output logic                             o_intr_en,
    output logic                             o_drain_req,
    output logic                             o_issue_stall,
    output logic                             o_call_issue_e1,
    output logic                             o_rps_push,
    output logic [63:0]                      o_rps_pc,
    output logic [63:0]                      o_exception_return_address,
    output logic [63:0]                      o_ipr_rdata,
    output logic                             o_shadow_hit,
    output logic [63:0]                      o_shadow_rdata
);

    // ========================================================
    // state
    typedef enum logic [2:0] {
        ST_RUN, ST_DRAIN, ST_ISSUE, ST_FLOW
    } disp_st_t;

    disp_st_t    st_q, st_d;
    logic [63:0] base_q, base_d;
    logic [63:0] era_q, era_d;
    logic [63:0] tgt_q, tgt_d;
    logic        priv_q, priv_d;
    logic        redir_q, redir_d;
    logic        push_q, push_d;
    logic [63:0] rps_q, rps_d;
    logic [1:0]  cnt_q, cnt_d;
    logic [63:0] scratch_q [SCRATCH_N];
    logic [63:0] shadow_q [handler_dispatch_pkg::SHADOW_N];
    logic [63:0] rdata_q, rdata_d;

    // base plus offset with the mode flag set
    function automatic logic [63:0] entry_pc(
        input logic [63:0] base, input logic [15:0] ofs);
        entry_pc = {base[63:16], base[15:0] + ofs} |
                   64'h0000_0000_0000_0001;
    endfunction : entry_pc

    // map a register number to its shadow slot, 8 means none
    function automatic logic [3:0] shadow_slot(input logic [4:0] n);
        if (n >= handler_dispatch_pkg::SHADOW_LO &&
            n <= handler_dispatch_pkg::SHADOW_HI)
            shadow_slot = {1'b0, 3'(n - handler_dispatch_pkg::SHADOW_LO)};
        else if (n == handler_dispatch_pkg::SHADOW_X)
            shadow_slot = 4'h7;
        else
            shadow_slot = 4'h8;
    endfunction : shadow_slot

    // ========================================================
    // trap selection
    logic        fltdis;
    logic        dmiss1_eff;
    logic        dmiss2_eff;
    logic        any_trap;
    logic [15:0] trap_ofs;
    logic        func_bad;
    logic [63:0] call_pc;

    always_comb begin
        fltdis     = i_trap.fltdis ||
                     (i_float_op && (!i_float_enable || i_float_bad_type));
        dmiss1_eff = i_trap.dmiss1 && !i_dsign_err;
        dmiss2_eff = i_trap.dmiss2 && !i_dsign_err;
        any_trap   = !i_replay && (i_trap.instruction_access_violation_entry || i_trap.intr ||
                     i_trap.itmiss || dmiss1_eff || dmiss2_eff ||
                     i_trap.unaligned_entry || i_trap.data_fault_entry || i_trap.mcheck ||
                     i_trap.illegal || i_trap.arithmetic_exception_entry || fltdis);
        trap_ofs   = handler_dispatch_pkg::OFS_FLTDIS;
        if (i_trap.arithmetic_exception_entry)   trap_ofs = handler_dispatch_pkg::OFS_ARITHMETIC_EXCEPTION_ENTRY;
        if (i_trap.illegal) trap_ofs = handler_dispatch_pkg::OFS_ILLEGAL;
        if (i_trap.mcheck)  trap_ofs = handler_dispatch_pkg::OFS_MCHECK;
        if (i_trap.data_fault_entry)  trap_ofs = handler_dispatch_pkg::OFS_DATA_FAULT_ENTRY;
        if (i_trap.unaligned_entry) trap_ofs = handler_dispatch_pkg::OFS_UNALIGNED_ENTRY;
        if (dmiss2_eff)     trap_ofs = handler_dispatch_pkg::OFS_DMISS2;
        if (dmiss1_eff)     trap_ofs = handler_dispatch_pkg::OFS_DMISS1;
        if (i_icache_miss) begin
            if (i_trap.intr)   trap_ofs = handler_dispatch_pkg::OFS_INTR;
            if (i_trap.itmiss) trap_ofs = handler_dispatch_pkg::OFS_ITMISS;
        end else begin
            if (i_trap.itmiss) trap_ofs = handler_dispatch_pkg::OFS_ITMISS;
            if (i_trap.intr)   trap_ofs = handler_dispatch_pkg::OFS_INTR;
        end
        if (i_trap.instruction_access_violation_entry) trap_ofs = handler_dispatch_pkg::OFS_INSTRUCTION_ACCESS_VIOLATION_ENTRY;

        func_bad = (i_call_func >= handler_dispatch_pkg::FUNC_BAD_LO &&
                    i_call_func <= handler_dispatch_pkg::FUNC_BAD_HI) ||
                   (i_call_func > handler_dispatch_pkg::FUNC_UNPRIV_MAX) ||
                   (i_call_func <= handler_dispatch_pkg::FUNC_PRIV_MAX &&
                    i_current_mode_field !=
                    handler_dispatch_pkg::MODE_KERNEL);
        // bit 13 set gives 2000, plus bit 12 gives 3000
        call_pc = {base_q[63:handler_dispatch_pkg::CALL_BASE_LSB], 1'b1,
                   i_call_func[7], i_call_func[5:0], 5'h00, 1'b1};
    end

    // ========================================================
    // dispatch sequencer
    always_comb begin
        st_d    = st_q;
        base_d  = base_q;
        era_d   = era_q;
        tgt_d   = tgt_q;
        priv_d  = priv_q;
        redir_d = 1'b0;
        push_d  = 1'b0;
        rps_d   = rps_q;
        cnt_d   = cnt_q;
        rdata_d = rdata_q;
        if (i_ipr_wr && priv_q && i_ipr_sel == 6'h3F)
            base_d = i_ipr_wdata;
        if (i_ipr_rd)
            rdata_d = (i_ipr_sel == 6'h3F) ? base_q :
                      (i_ipr_sel == 6'h3E) ? era_q :
                      (i_ipr_sel < 6'(SCRATCH_N)) ?
                      scratch_q[5'(i_ipr_sel)] :
                      64'h0000_0000_0000_0000;
        case (st_q)
            ST_RUN: begin
                if (i_return && priv_q) begin
                    tgt_d   = era_q;
                    priv_d  = era_q[0];
                    redir_d = 1'b1;
                end else if (any_trap || i_call) begin
                    st_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (i_drained) begin
                    st_d = ST_ISSUE;
                    if (any_trap) begin
                        era_d  = i_trap_pc;
                        tgt_d  = entry_pc(base_q, trap_ofs);
                        rps_d  = i_trap_precise ? i_trap_pc :
                                 i_later_pc;
                    end else begin
                        era_d  = i_call_next_pc;
                        rps_d  = i_call_next_pc;
                        tgt_d  = func_bad ?
                            entry_pc(base_q,
                                     handler_dispatch_pkg::OFS_ILLEGAL) :
                            call_pc;
                    end
                    push_d = 1'b1;
                end
            end
            ST_ISSUE: begin
                redir_d = 1'b1;
                priv_d  = 1'b1;
                cnt_d   = 2'(handler_dispatch_pkg::FLOW_MIN_CYC - 1);
                st_d    = ST_FLOW;
            end
            ST_FLOW: begin
                // hold the flow for its minimum length
                if (cnt_q == 2'h0) st_d = ST_RUN;
                else cnt_d = cnt_q - 2'h1;
            end
            default: st_d = ST_RUN;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q    <= ST_ISSUE;
            base_q  <= handler_dispatch_pkg::BASE_RESET;
            era_q   <= 64'h0000_0000_0000_0000;
            tgt_q   <= handler_dispatch_pkg::BASE_RESET |
                       64'h0000_0000_0000_0001;
            priv_q  <= 1'b1;
            redir_q <= 1'b0;
            push_q  <= 1'b0;
            rps_q   <= 64'h0000_0000_0000_0000;
            cnt_q   <= 2'h0;
            rdata_q <= 64'h0000_0000_0000_0000;
        end else begin
            st_q    <= st_d;
            base_q  <= base_d;
            era_q   <= era_d;
            tgt_q   <= tgt_d;
            priv_q  <= priv_d;
            redir_q <= redir_d;
            push_q  <= push_d;
            rps_q   <= rps_d;
            cnt_q   <= cnt_d;
            rdata_q <= rdata_d;
        end
    end

    // ========================================================
    // scratch and shadow storage, data only, no reset needed
    logic [3:0] wslot;
    logic [3:0] rslot;
    logic       shadow_on;

    always_comb begin
        shadow_on = priv_q && i_shadow_enable;
        wslot     = shadow_slot(i_gpr.num);
        rslot     = shadow_slot(i_gpr.num);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_ipr_wr && i_ipr_sel < 6'(SCRATCH_N))
            scratch_q[5'(i_ipr_sel)] <= i_ipr_wdata;
        if (i_gpr.we && shadow_on && !wslot[3])
            shadow_q[wslot[2:0]] <= i_gpr.wdata;
    end

    // ========================================================
    // outputs
    assign o_redirect       = redir_q;
    assign o_target_pc      = tgt_q;
    assign o_fetch_pc       = {tgt_q[63:2], 2'b00};
    assign o_priv_mode      = priv_q;
    assign o_istream_map_en = !priv_q;
    assign o_dstream_map_en = 1'b1;
    assign o_intr_en        = !priv_q;
    assign o_drain_req      = (st_q == ST_DRAIN);
    assign o_issue_stall    = (st_q != ST_RUN);
    assign o_call_issue_e1  = (st_q == ST_ISSUE) && i_call;
    assign o_rps_push       = push_q;
    assign o_rps_pc         = rps_q;
    assign o_exception_return_address = era_q;
    assign o_ipr_rdata      = rdata_q;
    assign o_shadow_hit     = shadow_on && !rslot[3];
    assign o_shadow_rdata   = shadow_q[rslot[2:0]];

    // ========================================================
    // checks
    sequence s_enter;
        (st_q == ST_ISSUE);
    endsequence

    sequence s_trap_go;
        (st_q == ST_DRAIN && i_drained && any_trap);
    endsequence

    sequence s_call_go;
        (st_q == ST_DRAIN && i_drained && !any_trap);
    endsequence

    a_entry_sets_flag: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) s_enter |=> o_priv_mode)
        else $error("mode flag not set on entry");
    a_drain_before_save: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) (st_q == ST_DRAIN && !i_drained) |=>
        $stable(era_q))
        else $error("return address changed before drain");
    a_return_mode: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) (st_q == ST_RUN && i_return && priv_q) |=>
        (o_priv_mode == $past(era_q[0]) && o_redirect))
        else $error("return did not take mode from bit 0");
    a_map_follows_mode: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) o_priv_mode |-> (!o_intr_en &&
        !o_istream_map_en && o_dstream_map_en))
        else $error("mapping or interrupts on in privileged mode");
    a_fetch_aligned: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) o_fetch_pc[1:0] == 2'b00)
        else $error("fetch pc not aligned");
    a_target_flag: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) (o_redirect && o_priv_mode) |->
        o_target_pc[0])
        else $error("entry target lacks mode flag");
    a_call_length: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) (st_q == ST_DRAIN && i_drained) |=>
        o_issue_stall [*3])
        else $error("handler call shorter than four cycles");
    a_replay_ignored: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) (st_q == ST_RUN && i_replay && !i_call &&
        !i_return) |=> st_q == ST_RUN)
        else $error("replay dispatched a handler");

    // dispatch steps: save, push, then redirect
    a_issue_redirects: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) s_enter |=> o_redirect)
        else $error("issue step did not redirect fetch");
    a_trap_saves_pc: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) s_trap_go |=>
        o_exception_return_address == $past(i_trap_pc))
        else $error("trap did not save its return pc");
    a_call_saves_next: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) s_call_go |=>
        (o_exception_return_address == $past(i_call_next_pc) &&
        o_rps_pc == $past(i_call_next_pc) && o_rps_push))
        else $error("call did not save the next pc");
    a_call_target: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) (st_q == ST_DRAIN && i_drained &&
        !any_trap && !func_bad) |=> (o_target_pc[13] &&
        o_target_pc[5:0] == 6'h01))
        else $error("call target layout wrong");
    a_push_then_redirect: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) o_rps_push |=> o_redirect)
        else $error("prediction push not followed by dispatch");
    a_base_guarded: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) (i_ipr_wr && !priv_q &&
        i_ipr_sel == 6'h3F) |=> $stable(base_q))
        else $error("base written outside privileged mode");
    a_shadow_native: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) !o_priv_mode |-> !o_shadow_hit)
        else $error("shadow overlay active in native mode");

endmodule : privileged_handler_dispatch

`default_nettype wire

// file: handler_dispatch_pkg.sv
// Purpose: shared constants and carriers for the handler dispatch unit
// Assumes: 64-bit program counter, 100 MHz core clock
// Notes:   entry offsets are byte offsets from the handler base
package handler_dispatch_pkg;

    // ========================================================
    // widths
    localparam int PC_W       = 64;
    localparam int FUNC_W     = 8;
    localparam int SCRATCH_N  = 24;
    localparam int SHADOW_N   = 8;

    // ========================================================
    // entry offsets
    localparam logic [15:0] OFS_RESET   = 16'h0000;
    localparam logic [15:0] OFS_INSTRUCTION_ACCESS_VIOLATION_ENTRY = 16'h0080;
    localparam logic [15:0] OFS_INTR    = 16'h0100;
    localparam logic [15:0] OFS_ITMISS  = 16'h0180;
    localparam logic [15:0] OFS_DMISS1  = 16'h0200;
    localparam logic [15:0] OFS_DMISS2  = 16'h0280;
    localparam logic [15:0] OFS_UNALIGNED_ENTRY = 16'h0300;
    localparam logic [15:0] OFS_DATA_FAULT_ENTRY  = 16'h0380;
    localparam logic [15:0] OFS_MCHECK  = 16'h0400;
    localparam logic [15:0] OFS_ILLEGAL = 16'h0480;
    localparam logic [15:0] OFS_ARITHMETIC_EXCEPTION_ENTRY   = 16'h0500;
    localparam logic [15:0] OFS_FLTDIS  = 16'h0580;

    // ========================================================
    // handler-call layout
    localparam int  CALL_BASE_LSB = 14;
    localparam int  CALL_FLAG_BIT = 13;
    localparam int  CALL_HI_BIT   = 12;
    localparam int  CALL_IDX_LSB  = 6;
    localparam logic [7:0] FUNC_PRIV_MAX   = 8'h3F;
    localparam logic [7:0] FUNC_BAD_LO     = 8'h40;
    localparam logic [7:0] FUNC_BAD_HI     = 8'h7F;
    localparam logic [7:0] FUNC_UNPRIV_MAX = 8'hBF;
    localparam logic [1:0] MODE_KERNEL     = 2'h0;

    // ========================================================
    // reset values and timing
    localparam logic [63:0] BASE_RESET = 64'h0000_0000_0000_0000;
    localparam int BARRIER_CYC = 1;
    localparam int FLOW_MIN_CYC = 2;

    // ========================================================
    // shadowed register numbers
    localparam logic [4:0] SHADOW_LO = 5'h08;
    localparam logic [4:0] SHADOW_HI = 5'h0E;
    localparam logic [4:0] SHADOW_X  = 5'h19;

    // trap requests, one bit per source
    typedef struct packed {
        logic instruction_access_violation_entry;
        logic intr;
        logic itmiss;
        logic dmiss1;
        logic dmiss2;
        logic unaligned_entry;
        logic data_fault_entry;
        logic mcheck;
        logic illegal;
        logic arithmetic_exception_entry;
        logic fltdis;
    } trap_req_t;

    // register-file access from the execution pipe
    typedef struct packed {
        logic       we;
        logic [4:0] num;
        logic [63:0] wdata;
    } gpr_acc_t;

endpackage : handler_dispatch_pkg

// file: pipe_model.sv
// Purpose: pipeline stand-in that answers drain requests
// Assumes: drain request is a level held while the unit drains
// Notes:   i_slow stretches the drain to mimic a busy pipeline
`timescale 1ns/1ps
`default_nettype none

module pipe_model (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // control from the dispatch unit and the bench
    input  wire logic i_drain_req,
    input  wire logic i_slow,
    // answer to the dispatch unit
    output logic      o_drained
);
    logic [2:0] wait_q;
    logic [2:0] wait_d;

    // ========================================================
    // drain counter
    always_comb begin
        wait_d = i_drain_req ? wait_q + 3'h1 : 3'h0;
        if (wait_q == 3'h7) begin
            wait_d = wait_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_q <= 3'h0;
        end else begin
            wait_q <= wait_d;
        end
    end

    // never reports empty before in-flight work has had time to retire
    assign o_drained = i_drain_req && (wait_q >= (i_slow ? 3'h4 : 3'h1));
endmodule : pipe_model
`default_nettype wire

// file: testbench.sv
// Purpose: self-checking bench for the handler dispatch unit
// Assumes: pipe_model answers drains; one event in flight at a time
// Notes:   each event ends with a return so the next one starts native
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ========================================================
    // stimulus and observation
    localparam logic [63:0] BASE = 64'h0000_0012_3456_C000;
    localparam logic [63:0] TPC  = 64'h0000_0000_0080_2000;
    localparam logic [63:0] LPC  = 64'h0000_0000_0080_2010;
    localparam logic [63:0] NPC  = 64'h0000_0000_0040_1004;
    localparam logic [7:0]  FN [9] = '{8'h83, 8'h01, 8'h01, 8'h50, 8'hC0,
                                       8'h3F, 8'hBF, 8'h7F, 8'h40};
    localparam logic [1:0]  MD [9] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h0,
                                       2'h0, 2'h2, 2'h0, 2'h0};
    logic        clk, rst_n, replay, dsign, icmiss, fop, fbad, prec;
    logic        call, ret, iwr, ird, shen, float_disabled_entry, slow, drained;
    logic        redir, priv, imap, dmap, ien, dreq, stall, e1, push;
    logic        shit, e1s;
    logic [1:0]  mode;
    logic [5:0]  isel;
    logic [7:0]  func;
    logic [63:0] iwd, tgt, fpc, rpc, era, ird_q, srd, rps_q;
    handler_dispatch_pkg::trap_req_t trap;
    handler_dispatch_pkg::gpr_acc_t  gpr;
    int          bad_count, checked, n;

    privileged_handler_dispatch i_privileged_handler_dispatch (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_trap(trap), .i_replay(replay),
        .i_dsign_err(dsign), .i_icache_miss(icmiss), .i_float_op(fop),
        .i_float_bad_type(fbad), .i_trap_precise(prec), .i_trap_pc(TPC),
        .i_later_pc(LPC), .i_call(call), .i_call_func(func),
        .i_call_next_pc(NPC), .i_return(ret), .i_drained(drained),
        .i_ipr_wr(iwr), .i_ipr_rd(ird), .i_ipr_sel(isel), .i_ipr_wdata(iwd),
        .i_shadow_enable(shen), .i_float_enable(float_disabled_entry),
        .i_current_mode_field(mode), .i_gpr(gpr), .o_redirect(redir),
        .o_target_pc(tgt), .o_fetch_pc(fpc), .o_priv_mode(priv),
        .o_istream_map_en(imap), .o_dstream_map_en(dmap), .o_intr_en(ien),
        .o_drain_req(dreq), .o_issue_stall(stall), .o_call_issue_e1(e1),
        .o_rps_push(push), .o_rps_pc(rpc),
        .o_exception_return_address(era), .o_ipr_rdata(ird_q),
        .o_shadow_hit(shit), .o_shadow_rdata(srd));

    pipe_model i_pipe_model (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_drain_req(dreq), .i_slow(slow), .o_drained(drained));

    always #5 clk = ~clk;

    // ========================================================
    // compare and closing tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask : chk1

    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // ========================================================
    // access tasks
    task automatic wait_redir();
        e1s = 1'b0;
        do begin
            @(posedge clk);
            ret <= 1'b0;
            #1;
            n++;
            if (push === 1'b1) rps_q = rpc;
            if (e1 === 1'b1) e1s = 1'b1;
        end while (redir !== 1'b1 && n < 40);
        chk1(redir, 1'b1);
    endtask : wait_redir

    task automatic wait_run();
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (stall !== 1'b0 && n < 80);
        chk1(stall, 1'b0);
    endtask : wait_run

    task automatic quiet();
        n = 0;
        repeat (8) begin
            @(posedge clk);
            ret <= 1'b0;
            #1;
            if (redir !== 1'b0) n++;
        end
        chk1(n == 0, 1'b1);
    endtask : quiet

    // waits out one entry, then drops the request
    task automatic fire(input logic [63:0] exp);
        n = 0;
        rps_q = 'x;
        wait_redir();
        chk(tgt, exp);
        chk(fpc, {exp[63:2], 2'b00});
        chk1(priv, 1'b1);
        chk1(imap | ien | !dmap, 1'b0);
        @(posedge clk);
        trap <= '0;
        call <= 1'b0;
        fop <= 1'b0;
        fbad <= 1'b0;
        wait_run();
        chk1(priv, 1'b1);
    endtask : fire

    task automatic back(input logic [63:0] exp);
        n = 0;
        @(posedge clk);
        ret <= 1'b1;
        wait_redir();
        chk(tgt, exp);
        chk1(priv, exp[0]);
        wait_run();
        chk1(imap & ien, 1'b1);
    endtask : back

    task automatic ipr_wr(input logic [5:0] s, input logic [63:0] d);
        @(posedge clk);
        iwr <= 1'b1;
        isel <= s;
        iwd <= d;
        @(posedge clk);
        iwr <= 1'b0;
    endtask : ipr_wr

    task automatic ipr_rd(input logic [5:0] s, input logic [63:0] exp);
        @(posedge clk);
        ird <= 1'b1;
        isel <= s;
        @(posedge clk);
        ird <= 1'b0;
        #1;
        chk(ird_q, exp);
    endtask : ipr_rd

    task automatic tcase(input logic [10:0] b, input logic ic, ds, p,
                         input logic [15:0] o);
        logic [63:0] t;
        t = BASE + {48'h0000_0000_0000, o};
        @(posedge clk);
        trap <= handler_dispatch_pkg::trap_req_t'(b);
        icmiss <= ic;
        dsign <= ds;
        prec <= p;
        slow <= o[8];
        fire(t | 64'h0000_0000_0000_0001);
        chk(rps_q, p ? TPC : LPC);
        chk(era, TPC);
        back(TPC);
    endtask : tcase

    task automatic ccase(input logic [7:0] f, input logic [1:0] m);
        logic [63:0] t;
        if ((f >= 8'h40 && f <= 8'h7F) || f > 8'hBF ||
            (f <= 8'h3F && m != 2'h0))
            t = BASE + 64'h0000_0000_0000_0481;
        else
            t = {BASE[63:14], 1'b1, f[7], f[5:0], 6'h01};
        @(posedge clk);
        call <= 1'b1;
        func <= f;
        mode <= m;
        fire(t);
        chk1(n >= 4, 1'b1);
        chk(era, NPC);
        chk(rps_q, NPC);
        chk1(e1s, 1'b1);
        back(NPC);
    endtask : ccase

    // ========================================================
    // main sequence
    initial begin
        {clk, rst_n, replay, dsign, icmiss, fop, fbad, prec} = '0;
        {call, ret, iwr, ird, shen, float_disabled_entry, slow, mode, isel, func} = '0;
        {trap, gpr, iwd, bad_count, checked} = '0;
        repeat (8) @(posedge clk);
        chk1(priv, 1'b1);
        rst_n <= 1'b1;
        n = 0;
        wait_redir();
        chk(tgt, 64'h0000_0000_0000_0001);
        wait_run();
        ipr_wr(6'h3F, BASE);
        ipr_wr(6'h00, TPC);
        ipr_wr(6'h17, LPC);
        ipr_rd(6'h00, TPC);
        ipr_rd(6'h17, LPC);
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            shen <= 1'b1;
            gpr <= '{1'b1, 5'(i), BASE + 64'(i)};
            @(posedge clk);
            gpr.we <= 1'b0;
            #1;
            chk1(shit, (i >= 8 && i <= 14) || i == 25);
            if (shit === 1'b1) chk(srd, BASE + 64'(i));
        end
        ccase(8'h83, 2'h3);
        ipr_rd(6'h3E, NPC);
        @(posedge clk);
        gpr.num <= 5'h08;
        #1;
        chk1(shit, 1'b0);
        @(posedge clk);
        ret <= 1'b1;
        quiet();
        ipr_wr(6'h3F, 64'h0000_0000_0000_0000);
        for (int i = 0; i < 9; i++) ccase(FN[i], MD[i]);
        for (int i = 0; i < 11; i++)
            tcase(11'h400 >> i, 1'b0, 1'b0, i[0],
                  16'(16'h0080 * (i + 1)));
        tcase(11'h7FF, 1'b0, 1'b0, 1'b1, 16'h0080);
        tcase(11'h300, 1'b0, 1'b0, 1'b1, 16'h0100);
        tcase(11'h300, 1'b1, 1'b0, 1'b1, 16'h0180);
        tcase(11'h0D0, 1'b0, 1'b1, 1'b1, 16'h0380);
        tcase(11'h00F, 1'b0, 1'b0, 1'b1, 16'h0400);
        tcase(11'h003, 1'b0, 1'b0, 1'b1, 16'h0500);
        @(posedge clk);
        trap <= handler_dispatch_pkg::trap_req_t'(11'h400);
        replay <= 1'b1;
        quiet();
        @(posedge clk);
        trap <= '0;
        replay <= 1'b0;
        fop <= 1'b1;
        fire(BASE + 64'h0000_0000_0000_0581);
        back(TPC);
        @(posedge clk);
        float_disabled_entry <= 1'b1;
        fop <= 1'b1;
        fbad <= 1'b1;
        fire(BASE + 64'h0000_0000_0000_0581);
        back(TPC);
        @(posedge clk);
        fop <= 1'b1;
        quiet();
        report_and_stop();
    end

    // a hang would otherwise hide behind the bounded waits
    initial begin
        #200_000;
        bad_count++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
